//--- hdl/ddc_burst_path.sv
// Summary of operation
// - Every channel always runs a first decimate-by-two stage, low or high pass.
// - Second stage demodulates to complex and decimates by two or four per mode.
// - Some modes turn complex back to real with a quarter output-rate mixer.
// - Pairs A/B and C/D each run burst or decimation on their own.
// - First stage halves the interleaved input rate; a control bit picks low or high pass.
// - Oscillator makes a complex tone from a 16-bit word and mixes samples down.
// - Oscillator frequency is word times sample rate over two to the sixteenth.
// - Mode 0 mixes by fixed quarter rate, decimates by two, outputs complex.
// - Mode 1 mixes by the oscillator, decimates by two, outputs complex.
// - Mode 2 cascades two selectable decimate-by-two filters, real output.
// - Mode 3 oscillator then quarter mixer, no second stage; quarter word zeroes.
// - Mode 4 oscillator, decimate by two, then quarter output-rate mix, real.
// - Mode 6 oscillator then complex decimate by four, complex output.
// - Mode 7 as mode 4, then a zero inserted after every sample.
// - Burst mode outputs first-stage samples directly, no mixing or second stage.
// - Burst mode alternates runs of 9-bit and 14-bit samples.
// - Each pair has its own high and low counts set by register writes.
// - Counts breaking 1:3 high to low duty are replaced by defaults, high count 1.
// - Each burst cycle starts low; new counts apply from the next cycle.
// - A cycle emits twice high count high samples and twice low count low.
// - Auto trigger starts high at once; manual waits for the pair trigger pin.
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ddc_burst_path
  import ddc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_CH-1:0][ADC_W-1:0] adc_even,
  input wire logic [NUM_CH-1:0][ADC_W-1:0] adc_odd,
  input wire logic pair1_trigger_pin,
  input wire logic pair2_trigger_pin,
  output sample_type [NUM_CH-1:0] sample_out
);

  // ****************************************
  // Register file
  // ****************************************
  logic [NUM_PAIRS-1:0][31:0] ctrl_q;
  logic [NUM_CH-1:0][FW_W-1:0] oscillator_frequency_word;
  logic [NUM_PAIRS-1:0][HC_W-1:0] high_res_count;
  logic [NUM_PAIRS-1:0][LC_W-1:0] low_res_count;
  logic [NUM_PAIRS-1:0] high_res_flag;
  logic [NUM_PAIRS-1:0] forced_flag;
  logic [NUM_PAIRS-1:0] pair_trigger;
  logic wr_en;
  logic [31:0] rd_data;

  assign pair_trigger = {pair2_trigger_pin, pair1_trigger_pin};
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      wb_ack_o <= 1'b0;
    else if (ce)
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      wb_dat_o <= '0;
    else if (ce && wb_cyc_i && wb_stb_i && !wb_ack_o)
      wb_dat_o <= rd_data;
  end

  always_comb
  begin
    rd_data = '0;
    for (int p = 0; p < NUM_PAIRS; p++)
    begin
      if (wb_adr_i == CTRL_BASE_OFS + 8'(4 * p))
        rd_data = ctrl_q[p];
      if (wb_adr_i == HC_BASE_OFS + 8'(p) * PAIR_STRIDE)
        rd_data = 32'(high_res_count[p]);
      if (wb_adr_i == LC_BASE_OFS + 8'(p) * PAIR_STRIDE)
        rd_data = 32'(low_res_count[p]);
    end
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (wb_adr_i == FREQ_BASE_OFS + 8'(4 * c))
        rd_data = 32'(oscillator_frequency_word[c]);
    end
    if (wb_adr_i == STATUS_OFS)
    begin
      rd_data[NUM_PAIRS-1:0] = high_res_flag;
      rd_data[STAT_FORCED_LSB +: NUM_PAIRS] = forced_flag;
      for (int p = 0; p < NUM_PAIRS; p++)
        rd_data[STAT_BURST_LSB + p] = (ctrl_q[p][CTRL_MODE_LSB +: 4] == MODE_BURST);
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_q <= {NUM_PAIRS{CTRL_RST}};
      high_res_count <= {NUM_PAIRS{HC_DEFAULT}};
      low_res_count <= {NUM_PAIRS{LC_DEFAULT}};
    end
    else if (ce && wr_en)
    begin
      for (int p = 0; p < NUM_PAIRS; p++)
      begin
        if (wb_adr_i == CTRL_BASE_OFS + 8'(4 * p))
          ctrl_q[p] <= merge(ctrl_q[p], wb_dat_i, wb_sel_i);
        if (wb_adr_i == HC_BASE_OFS + 8'(p) * PAIR_STRIDE)
          high_res_count[p] <= HC_W'(merge(32'(high_res_count[p]), wb_dat_i, wb_sel_i));
        if (wb_adr_i == LC_BASE_OFS + 8'(p) * PAIR_STRIDE)
          low_res_count[p] <= LC_W'(merge(32'(low_res_count[p]), wb_dat_i, wb_sel_i));
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      oscillator_frequency_word <= '0;
    else if (ce && wr_en)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (wb_adr_i == FREQ_BASE_OFS + 8'(4 * c))
          oscillator_frequency_word[c] <= FW_W'(merge(32'(oscillator_frequency_word[c]), wb_dat_i,
                                                      wb_sel_i));
      end
    end
  end

  // ****************************************
  // Burst sequencers, one per pair
  // ****************************************
  for (genvar p = 0; p < NUM_PAIRS; p++)
  begin : g_pair
    burst_cfg_type cfg;
    assign cfg = '{high_res_count: high_res_count[p], low_res_count: low_res_count[p],
                   manual: ctrl_q[p][CTRL_MANUAL_BIT]};
    burst_sequencer u_seq (
      .mclk(mclk),
      .rst_b(rst_b),
      .ce(ce),
      .enable(ctrl_q[p][CTRL_MODE_LSB +: 4] == MODE_BURST),
      .trigger(pair_trigger[p]),
      .cfg(cfg),
      .high_res_q(high_res_flag[p]),
      .forced_q(forced_flag[p])
    );
  end

  // ****************************************
  // Channel data paths
  // ****************************************
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    localparam int P = c / 2;
    logic [3:0] mode;
    logic signed [ADC_W-1:0] s1;
    logic signed [OUT_W-1:0] xe;
    logic [1:0] qph_q;
    logic [FW_W-1:0] nco_acc_q;
    logic signed [COEF_W-1:0] cos_v;
    logic signed [COEF_W-1:0] sin_v;
    logic signed [ADC_W+COEF_W-1:0] prod_c;
    logic signed [ADC_W+COEF_W-1:0] prod_s;
    logic signed [OUT_W-1:0] mi_d;
    logic signed [OUT_W-1:0] mq_d;
    logic signed [OUT_W-1:0] mi_q;
    logic signed [OUT_W-1:0] mq_q;
    logic [1:0] cnt2_q;
    logic [1:0] last2;
    logic signed [OUT_W+1:0] acc_i_q;
    logic signed [OUT_W+1:0] acc_q_q;
    logic signed [OUT_W+1:0] sum_i;
    logic signed [OUT_W+1:0] sum_q;
    logic signed [OUT_W-1:0] term_i;
    logic signed [OUT_W-1:0] d_i_q;
    logic signed [OUT_W-1:0] d_q_q;
    logic d_v_q;
    logic [1:0] ocnt_q;
    logic stuff_q;
    logic signed [OUT_W-1:0] real_v;
    logic nco_quarter;

    assign mode = ctrl_q[P][CTRL_MODE_LSB +: 4];

    stage1_decim #(.W(ADC_W)) u_s1 (
      .mclk(mclk),
      .rst_b(rst_b),
      .ce(ce),
      .hp(ctrl_q[P][CTRL_S1_HP_BIT]),
      .even_in(adc_even[c]),
      .odd_in(adc_odd[c]),
      .y_q(s1)
    );

    assign xe = OUT_W'(s1);

    // Phase of fixed quarter mixer and oscillator accumulator
    always_ff @(posedge mclk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        qph_q <= '0;
        nco_acc_q <= '0;
      end
      else if (ce)
      begin
        qph_q <= qph_q + 2'h1;
        nco_acc_q <= nco_acc_q + oscillator_frequency_word[c];
      end
    end

    assign cos_v = COS_LUT[nco_acc_q[FW_W-1 -: 3]];
    assign sin_v = COS_LUT[nco_acc_q[FW_W-1 -: 3] - 3'h2];
    assign prod_c = $signed(xe[ADC_W-1:0]) * cos_v;
    assign prod_s = $signed(xe[ADC_W-1:0]) * sin_v;

    // First mixer: quarter rate, oscillator, or pass through
    always_comb
    begin
      mi_d = xe;
      mq_d = '0;
      if (mode == MODE_FS4_IQ)
      begin
        unique case (qph_q)
          2'h0: mi_d = xe;
          2'h1: mi_d = '0;
          2'h2: mi_d = -xe;
          2'h3: mi_d = '0;
        endcase
        unique case (qph_q)
          2'h0: mq_d = '0;
          2'h1: mq_d = ctrl_q[P][CTRL_MIX_NEG_BIT] ? -xe : xe;
          2'h2: mq_d = '0;
          2'h3: mq_d = ctrl_q[P][CTRL_MIX_NEG_BIT] ? xe : -xe;
        endcase
      end
      else if (mode != MODE_REAL_CASCADE && mode != MODE_BURST)
      begin
        mi_d = OUT_W'(prod_c >>> COEF_SHIFT);
        mq_d = -OUT_W'(prod_s >>> COEF_SHIFT);
      end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        mi_q <= '0;
        mq_q <= '0;
      end
      else if (ce)
      begin
        mi_q <= mi_d;
        mq_q <= mq_d;
      end
    end

    // Second stage: decimate by two, four, or bypass
    assign last2 = (mode == MODE_NCO_DEC4) ? 2'h3 : (mode == MODE_NCO_SHIFT) ? 2'h0 : 2'h1;
    assign term_i = (mode == MODE_REAL_CASCADE && ctrl_q[P][CTRL_S2_HP_BIT] && cnt2_q[0]) ? -mi_q : mi_q;
    assign sum_i = (cnt2_q == 2'h0) ? (OUT_W+2)'(term_i) : acc_i_q + (OUT_W+2)'(term_i);
    assign sum_q = (cnt2_q == 2'h0) ? (OUT_W+2)'(mq_q) : acc_q_q + (OUT_W+2)'(mq_q);

    always_ff @(posedge mclk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        cnt2_q <= '0;
        acc_i_q <= '0;
        acc_q_q <= '0;
        d_i_q <= '0;
        d_q_q <= '0;
        d_v_q <= 1'b0;
      end
      else if (ce)
      begin
        acc_i_q <= sum_i;
        acc_q_q <= sum_q;
        d_v_q <= (cnt2_q == last2);
        cnt2_q <= (cnt2_q == last2) ? 2'h0 : cnt2_q + 2'h1;
        if (cnt2_q == last2)
        begin
          d_i_q <= OUT_W'(sum_i >>> cnt2_q[1:1] >>> (cnt2_q != 2'h0));
          d_q_q <= OUT_W'(sum_q >>> cnt2_q[1:1] >>> (cnt2_q != 2'h0));
        end
      end
    end

    // Output quarter mixer and zero stuffing state
    assign nco_quarter = (oscillator_frequency_word[c] == NCO_PLUS_QUARTER) ||
                         (oscillator_frequency_word[c] == NCO_MINUS_QUARTER);

    always_comb
    begin
      unique case (ocnt_q)
        2'h0: real_v = d_i_q;
        2'h1: real_v = -d_q_q;
        2'h2: real_v = -d_i_q;
        2'h3: real_v = d_q_q;
      endcase
      if (mode == MODE_NCO_SHIFT && nco_quarter)
        real_v = '0;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        ocnt_q <= '0;
        stuff_q <= 1'b0;
      end
      else if (ce)
      begin
        if (d_v_q)
          ocnt_q <= ocnt_q + 2'h1;
        stuff_q <= d_v_q && (mode == MODE_ZERO_STUFF);
      end
    end

    // Output register
    always_ff @(posedge mclk or negedge rst_b)
    begin
      if (!rst_b)
        sample_out[c] <= '0;
      else if (ce)
      begin
        sample_out[c] <= '0;
        if (mode == MODE_BURST)
        begin
          sample_out[c].valid <= 1'b1;
          sample_out[c].high_res <= high_res_flag[P];
          sample_out[c].i <= high_res_flag[P] ? xe :
                             (xe & ~OUT_W'((1 << (ADC_W - LOW_RES_W)) - 1));
        end
        else if (d_v_q)
        begin
          sample_out[c].valid <= (mode != 4'h5) && (mode <= MODE_ZERO_STUFF);
          unique case (mode)
            MODE_FS4_IQ, MODE_NCO_IQ, MODE_NCO_DEC4:
            begin
              sample_out[c].i <= d_i_q;
              sample_out[c].q <= d_q_q;
            end
            MODE_REAL_CASCADE:
              sample_out[c].i <= d_i_q;
            MODE_NCO_SHIFT, MODE_NCO_REAL, MODE_ZERO_STUFF:
              sample_out[c].i <= real_v;
            default:
              sample_out[c].i <= '0;
          endcase
        end
        else if (stuff_q)
          sample_out[c].valid <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

//--- shared/ddc_pkg.sv
package ddc_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_CH = 4;
  localparam int NUM_PAIRS = 2;
  localparam int ADC_W = 14;
  localparam int OUT_W = 16;
  localparam int LOW_RES_W = 9;
  localparam int HC_W = 26;
  localparam int LC_W = 28;
  localparam int FW_W = 16;
  localparam int COEF_W = 12;
  localparam int COEF_SHIFT = 11;
  localparam int DUTY_LOW_PER_HIGH = 3;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTRL_BASE_OFS = 8'h00;
  localparam logic [7:0] FREQ_BASE_OFS = 8'h08;
  localparam logic [7:0] HC_BASE_OFS = 8'h18;
  localparam logic [7:0] LC_BASE_OFS = 8'h1c;
  localparam logic [7:0] PAIR_STRIDE = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h28;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_S1_HP_BIT = 4;
  localparam int CTRL_S2_HP_BIT = 5;
  localparam int CTRL_MIX_NEG_BIT = 6;
  localparam int CTRL_MANUAL_BIT = 7;
  localparam int STAT_FORCED_LSB = 2;
  localparam int STAT_BURST_LSB = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0040;
  localparam logic [HC_W-1:0] HC_DEFAULT = 26'h000_0001;
  localparam logic [LC_W-1:0] LC_DEFAULT = 28'h000_0003;

  // ****************************************
  // Operating modes and oscillator
  // ****************************************
  localparam logic [3:0] MODE_FS4_IQ = 4'h0;
  localparam logic [3:0] MODE_NCO_IQ = 4'h1;
  localparam logic [3:0] MODE_REAL_CASCADE = 4'h2;
  localparam logic [3:0] MODE_NCO_SHIFT = 4'h3;
  localparam logic [3:0] MODE_NCO_REAL = 4'h4;
  localparam logic [3:0] MODE_NCO_DEC4 = 4'h6;
  localparam logic [3:0] MODE_ZERO_STUFF = 4'h7;
  localparam logic [3:0] MODE_BURST = 4'h8;
  localparam logic [FW_W-1:0] NCO_PLUS_QUARTER = 16'h4000;
  localparam logic [FW_W-1:0] NCO_MINUS_QUARTER = 16'hc000;
  localparam logic signed [COEF_W-1:0] COS_LUT [8] = '{12'sh7ff, 12'sh5a8, 12'sh000, -12'sh5a8,
                                                       -12'sh7ff, -12'sh5a8, 12'sh000, 12'sh5a8};

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic valid;
    logic high_res;
    logic signed [OUT_W-1:0] i;
    logic signed [OUT_W-1:0] q;
  } sample_type;

  typedef struct packed {
    logic [HC_W-1:0] high_res_count;
    logic [LC_W-1:0] low_res_count;
    logic manual;
  } burst_cfg_type;

endpackage

//--- hdl/stage1_decim.sv
`timescale 1ns/1ps
`default_nettype none
module stage1_decim
  import ddc_pkg::*;
#(
  parameter int W = ADC_W
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic hp,
  input wire logic signed [W-1:0] even_in,
  input wire logic signed [W-1:0] odd_in,
  output logic signed [W-1:0] y_q
);

  generate
    if (W < 2)
    begin : g_chk
      $error("stage1_decim width too small");
    end
  endgenerate

  logic signed [W:0] sum_d;

  // Two interleaved samples in, one out per clock; high pass flips odd tap
  always_comb
  begin
    if (hp)
      sum_d = (W+1)'(even_in) - (W+1)'(odd_in);
    else
      sum_d = (W+1)'(even_in) + (W+1)'(odd_in);
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      y_q <= '0;
    else if (ce)
      y_q <= sum_d[W:1];
  end

endmodule
`default_nettype wire

//--- hdl/burst_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module burst_sequencer
  import ddc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic enable,
  input wire logic trigger,
  input wire burst_cfg_type cfg,
  output logic high_res_q,
  output logic forced_q
);

  typedef enum {ST_LOW, ST_WAIT_TRIG, ST_HIGH} burst_state_type;

  burst_state_type state_q;
  logic [LC_W:0] cnt_q;
  logic [HC_W-1:0] hc_q;
  logic [LC_W-1:0] lc_q;
  logic violation;
  logic low_done;
  logic high_done;

  // Low count must be at least three times the high count
  assign violation = (cfg.high_res_count == '0) || (cfg.low_res_count == '0) ||
                     ((LC_W+2)'(cfg.high_res_count) * (LC_W+2)'(DUTY_LOW_PER_HIGH) >
                      (LC_W+2)'(cfg.low_res_count));
  assign low_done = (cnt_q == {lc_q, 1'b0} - (LC_W+1)'(1));
  assign high_done = (cnt_q == (LC_W+1)'({hc_q, 1'b0}) - (LC_W+1)'(1));

  // ****************************************
  // Cycle start latches counts
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hc_q <= HC_DEFAULT;
      lc_q <= LC_DEFAULT;
      forced_q <= 1'b0;
    end
    else if (ce && (!enable || (state_q == ST_HIGH && high_done)))
    begin
      hc_q <= violation ? HC_DEFAULT : cfg.high_res_count;
      lc_q <= violation ? LC_DEFAULT : cfg.low_res_count;
      forced_q <= violation;
    end
  end

  // ****************************************
  // Low, optional trigger wait, high
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_LOW;
      cnt_q <= '0;
    end
    else if (ce)
    begin
      if (!enable)
      begin
        state_q <= ST_LOW;
        cnt_q <= '0;
      end
      else
      begin
        unique case (state_q)
          ST_LOW:
          begin
            cnt_q <= low_done ? '0 : cnt_q + (LC_W+1)'(1);
            if (low_done)
              state_q <= cfg.manual ? ST_WAIT_TRIG : ST_HIGH;
          end
          ST_WAIT_TRIG:
          begin
            if (trigger)
              state_q <= ST_HIGH;
          end
          ST_HIGH:
          begin
            cnt_q <= high_done ? '0 : cnt_q + (LC_W+1)'(1);
            if (high_done)
              state_q <= ST_LOW;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      high_res_q <= 1'b0;
    else if (ce)
      high_res_q <= enable && ((state_q == ST_HIGH && !high_done) || (state_q == ST_LOW && low_done &&
                    !cfg.manual) || (state_q == ST_WAIT_TRIG && trigger));
  end

endmodule
`default_nettype wire

//--- tb/ddc_burst_path_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ddc_burst_path_chk
  import ddc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire sample_type [NUM_CH-1:0] sample_out
);
  logic [31:0] lo_run_q;
  logic [31:0] hi_run_q;
  logic hr0;
  logic v0;
  assign hr0 = sample_out[0].high_res;
  assign v0 = sample_out[0].valid;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ****
  // Run lengths of channel A
  // ****
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lo_run_q <= 32'h0;
      hi_run_q <= 32'h0;
    end
    else if (ce)
    begin
      lo_run_q <= hr0 ? 32'h0 : lo_run_q + {31'h0, v0};
      hi_run_q <= hr0 ? hi_run_q + 32'h1 : 32'h0;
    end
  end
  // ****
  // Properties
  // ****
  ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h2c |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  hr_valid_a: assert property (hr0 |-> v0)
    else $error("high-res flag without sample");
  pair_lockstep_a: assert property (sample_out[0].high_res == sample_out[1].high_res
    && sample_out[2].high_res == sample_out[3].high_res)
    else $error("pair channels out of step");
  high_pair_a: assert property ($rose(hr0) |-> hr0[*2])
    else $error("high run shorter than two");
  low_run_min_a: assert property ($rose(hr0) |-> lo_run_q >= 32'h6)
    else $error("low run shorter than six");
  high_even_a: assert property ($fell(hr0) |-> hi_run_q[0] == 1'b0)
    else $error("odd high run length");
  burst_stream_a: assert property (hr0 |=> v0)
    else $error("burst stream gap");
endmodule
bind ddc_burst_path ddc_burst_path_chk u_chk (.mclk(mclk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sample_out(sample_out));
`default_nettype wire

//--- tb/sample_sink.sv
`timescale 1ns/1ps
`default_nettype none
module sample_sink
  import ddc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire sample_type [NUM_CH-1:0] sample_out,
  output logic [NUM_CH-1:0][31:0] valid_cnt_q
);
  // Link side takes one sample per valid pulse
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      valid_cnt_q <= '0;
    end
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        valid_cnt_q[c] <= valid_cnt_q[c] + {31'h0, sample_out[c].valid};
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ddc_pkg::*;
  logic mclk, rst_b, ce, cyc, stb, we, ack, trig1, trig2;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, dout, rdat, c0, r;
  logic [NUM_CH-1:0][ADC_W-1:0] ev, od;
  sample_type [NUM_CH-1:0] so, so0;
  logic [NUM_CH-1:0][31:0] vcnt;
  logic [15:0] lf;
  int error_cnt, check_count, lo, hi, bad, z, n;
  ddc_burst_path DUT (.mclk(mclk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack), .adc_even(ev),
    .adc_odd(od), .pair1_trigger_pin(trig1), .pair2_trigger_pin(trig2), .sample_out(so));
  sample_sink u_sink (.mclk(mclk), .rst_b(rst_b), .sample_out(so), .valid_cnt_q(vcnt));
  // ****
  // Helpers
  // ****
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] exp_valid(input int m);
    case (m)
      3, 7: return 32'h28;
      5: return 32'h0;
      6: return 32'ha;
      default: return 32'h14;
    endcase
  endfunction
  task automatic test_done;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    rdat = dout;
    if (k >= 20)
    begin
      error_cnt++;
      test_done;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, rdat & m, e);
  endtask
  task automatic runs(input int ch);
    int k;
    k = 0;
    @(negedge mclk);
    while (so[ch].high_res !== 1'b0 && k < 400)
    begin
      @(negedge mclk);
      k++;
    end
    while (so[ch].high_res !== 1'b1 && k < 400)
    begin
      @(negedge mclk);
      k++;
    end
    hi = 0;
    while (so[ch].high_res === 1'b1 && hi < 400)
    begin
      @(negedge mclk);
      hi++;
    end
    lo = 0;
    bad = 0;
    while (so[ch].high_res === 1'b0 && lo < 400)
    begin
      if (so[ch].i[4:0] !== 5'h0)
        bad++;
      @(negedge mclk);
      lo++;
    end
    if (k >= 400 || hi >= 400 || lo >= 400)
    begin
      error_cnt++;
      test_done;
    end
  endtask
  // ****
  // Clock and random samples
  // ****
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    lf <= lfsr_next(lf);
    ev <= {NUM_CH{lf[13:0]}};
    od <= {NUM_CH{lf[15:2]}};
    trig1 <= lf[15];
  end
  // ****
  // Main sequence
  // ****
  initial
  begin
    rst_b = 1'b0;
    ce = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    sel = 4'hf;
    wdat = 32'h0;
    lf = 16'h9060;
    ev = '0;
    od = '0;
    trig1 = 1'b0;
    trig2 = 1'b0;
    error_cnt = 0;
    check_count = 0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    rd(8'h00, 32'hffffffff, CTRL_RST, "ctrl_ab");
    rd(8'h04, 32'hffffffff, CTRL_RST, "ctrl_cd");
    rd(8'h18, 32'hffffffff, {6'h0, HC_DEFAULT}, "hc_ab");
    rd(8'h24, 32'hffffffff, {4'h0, LC_DEFAULT}, "lc_cd");
    bus(1'b1, 8'h30, 32'hffffffff);
    rd(8'h30, 32'hffffffff, 32'h0, "unmapped");
    for (int c = 0; c < NUM_CH; c++)
    begin
      r = {16'h0, lf};
      bus(1'b1, FREQ_BASE_OFS + 8'(4 * c), r | 32'hffff0000);
      rd(FREQ_BASE_OFS + 8'(4 * c), 32'hffffffff, r, "freq");
    end
    for (int m = 0; m < 8; m++)
    begin
      bus(1'b1, 8'h00, {25'h0, lf[2:0], 4'(m)});
      bus(1'b1, 8'h04, {25'h0, lf[2:0], 4'(m)});
      repeat (20) @(negedge mclk);
      c0 = vcnt[0];
      bad = 0;
      z = 0;
      repeat (40)
      begin
        @(negedge mclk);
        if (so[0].valid === 1'b1 && so[0].q !== 16'sh0)
          bad++;
        if (so[0].valid === 1'b1 && so[0].i === 16'sh0)
          z++;
      end
      chk("cadence", vcnt[0] - c0, exp_valid(m));
      if (m == 2 || m == 3 || m == 4 || m == 7)
        chk("real_q", 32'(bad), 32'h0);
      if (m == 7)
        chk("stuffed", 32'(z >= 20), 32'h1);
    end
    bus(1'b1, 8'h08, {16'h0, NCO_PLUS_QUARTER});
    bus(1'b1, 8'h00, {28'h0, MODE_NCO_SHIFT});
    repeat (20) @(negedge mclk);
    bad = 0;
    repeat (20)
    begin
      @(negedge mclk);
      if (so[0].i !== 16'sh0)
        bad++;
    end
    chk("quarter_zero", 32'(bad), 32'h0);
    bus(1'b1, 8'h00, {28'h0, MODE_BURST});
    runs(0);
    runs(0);
    chk("hi_def", 32'(hi), 32'h2);
    chk("lo_def", 32'(lo), 32'h6);
    chk("low_lsb", 32'(bad), 32'h0);
    bus(1'b1, 8'h18, 32'h2);
    bus(1'b1, 8'h1c, 32'h6);
    runs(0);
    runs(0);
    chk("hi_new", 32'(hi), 32'h4);
    chk("lo_new", 32'(lo), 32'hc);
    rd(8'h28, 32'h3c, 32'h10, "status");
    bus(1'b1, 8'h1c, 32'h5);
    runs(0);
    runs(0);
    chk("hi_forced", 32'(hi), 32'h2);
    chk("lo_forced", 32'(lo), 32'h6);
    rd(8'h28, 32'h3c, 32'h14, "forced");
    bus(1'b1, 8'h04, 32'h88);
    bad = 0;
    repeat (60)
    begin
      @(negedge mclk);
      if (so[2].high_res !== 1'b0)
        bad++;
    end
    chk("held_low", 32'(bad), 32'h0);
    @(posedge mclk);
    trig2 <= 1'b1;
    n = 0;
    while (so[2].high_res !== 1'b1 && n < 10)
    begin
      @(negedge mclk);
      n++;
    end
    chk("released", 32'(n < 10), 32'h1);
    @(posedge mclk);
    ce <= 1'b0;
    @(negedge mclk);
    so0 = so;
    bad = 0;
    repeat (20)
    begin
      @(negedge mclk);
      if (so !== so0)
        bad++;
    end
    chk("ce_hold", 32'(bad), 32'h0);
    @(posedge mclk);
    ce <= 1'b1;
    test_done;
  end
endmodule
`default_nettype wire
